/* verilog/bcr_consts.svh */
// constants for the backlight control register bank: offsets, fields, defaults, times
// assumes a single 50 MHz clock; times are whole microseconds in ns, turned into cycles by BCR_CYC
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

`define BCR_CLK_MHZ         50
// divide first: the longest step times the clock rate would overflow 32-bit math
`define BCR_CYC(ns)         ((ns) / 1000 * `BCR_CLK_MHZ)

`define BCR_ADDR_MASTER     8'h00
`define BCR_ADDR_SINK       8'h10
`define BCR_ADDR_CONFIG     8'h20
`define BCR_ADDR_OPTIONS    8'h30
`define BCR_ADDR_STATUS     8'h40

`define BCR_BIT_GROUP_A     2
`define BCR_BIT_GROUP_B     1
`define BCR_BIT_SOFT_RST    0
`define BCR_BIT_TIMERFLAG   4

`define BCR_MASK_MASTER     8'h06
`define BCR_MASK_SINK       8'h3F
`define BCR_MASK_CONFIG     8'hCF
`define BCR_MASK_OPTIONS    8'hFF

`define BCR_RST_MASTER      8'h00
`define BCR_RST_SINK        8'h00
`define BCR_RST_CONFIG      8'h0C
`define BCR_RST_OPTIONS     8'h00

`define BCR_STEP0_NS        6000
`define BCR_STEP1_NS        770000
`define BCR_STEP2_NS        1500000
`define BCR_STEP3_NS        3000000
`define BCR_STEP4_NS        6000000
`define BCR_STEP5_NS        12000000
`define BCR_STEP6_NS        25000000
`define BCR_STEP7_NS        50000000

`define BCR_FILT0_NS        3000000
`define BCR_FILT1_NS        800000
`define BCR_FILT2_NS        20000
`define BCR_FILT3_NS        1000

`endif

/* verilog/bcr_pkg.sv */
// types shared by the backlight control register bank
// assumes the constants header is included by the design files
package bcr_pkg;

   // byte access handed over by the serial protocol engine
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } bcr_regreq_t;

   typedef struct packed {
      logic       intEnable;
      logic       linearCurve;
      logic [1:0] unused;
      logic       sink6GroupSelect;
      logic       sink5GroupSelect;
      logic       pulseActiveLow;
      logic       pulseEnable;
   } bcr_config_t;

   typedef struct packed {
      logic [1:0] pumpGainChangeFilter;
      logic [2:0] rampDownStepTime;
      logic [2:0] rampUpStepTime;
   } bcr_options_t;

endpackage

/* verilog/bcr_interval_timer.sv */
// interval timer: one-cycle tick every period cycles while run is high
// assumes period is at least one and stays put while running
`timescale 1ns/100ps
`include "bcr_consts.svh"

module bcr_interval_timer
   import bcr_pkg::*;
#(
   parameter int CW = 22
) (
   input  wire logic          clock,
   input  wire logic          srst,
   input  wire logic          run,
   input  wire logic [CW-1:0] period,
   output logic               tick
);

   if (CW < 1) begin : g_check
      $error("bcr_interval_timer: CW must be at least one");
   end

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic          tick_q;
   logic          tick_d;

   always_comb begin
      count_d = count_q;
      tick_d  = 1'b0;
      if (!run) begin
         count_d = '0;
      end else if (count_q >= period - CW'(1)) begin
         count_d = '0;
         tick_d  = 1'b1;
      end else begin
         count_d = count_q + CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         count_q <= '0;
         tick_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q  <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

/* verilog/bcr_backlight_regs.sv */
// control register bank of a six-channel backlight driver
// assumes the serial engine hands over decoded byte writes and reads, one per cycle,
// and that all inputs are synchronous to clock
//
// Behaviour
// RULE1: master bit 2 switches every group A sink on or off; resets zero.
// RULE2: master bit 1 switches every group B sink on or off; resets zero.
// RULE3: writing one to master bit 0 restores all defaults, then bit clears itself.
// RULE4: sink enable bits 0..5 switch sinks one to six; reset zero.
// RULE5: config bit 7 gates the interrupt pin; cleared keeps it inactive.
// RULE6: a read of address 0x40 clears the pending interrupt.
// RULE7: config bit 6 picks linear curve for group A, else exponential.
// RULE8: config bit 3 puts sink six in group A when set, default set.
// RULE9: config bit 2 puts sink five in group A when set, default set.
// RULE10: config bit 1 sets pulse input polarity; zero is active high.
// RULE11: config bit 0 makes the pulse input honoured; cleared ignores it.
// RULE12: options bits 7:6 pick the charge pump gain change filter time.
// RULE13: options bits 5:3 pick the ramp down step time, 6us to 50ms.
// RULE14: options bits 2:0 pick the ramp up step time; reset code 000.
// RULE15: hardware enable low restores all defaults and disables the device.
// RULE16: host writes send device address, register address byte, then data byte.
// RULE17: undefined bits read as zero and ignore writes.
`timescale 1ns/100ps
`include "bcr_consts.svh"

module bcr_backlight_regs
   import bcr_pkg::*;
#(
   parameter int          CW               = 22,
   parameter int unsigned STEP_CYCLES [8]  = '{`BCR_CYC(`BCR_STEP0_NS),
                                               `BCR_CYC(`BCR_STEP1_NS),
                                               `BCR_CYC(`BCR_STEP2_NS),
                                               `BCR_CYC(`BCR_STEP3_NS),
                                               `BCR_CYC(`BCR_STEP4_NS),
                                               `BCR_CYC(`BCR_STEP5_NS),
                                               `BCR_CYC(`BCR_STEP6_NS),
                                               `BCR_CYC(`BCR_STEP7_NS)},
   parameter int unsigned FILTER_CYCLES [4] = '{`BCR_CYC(`BCR_FILT0_NS),
                                               `BCR_CYC(`BCR_FILT1_NS),
                                               `BCR_CYC(`BCR_FILT2_NS),
                                               `BCR_CYC(`BCR_FILT3_NS)}
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        hardwareEnablePin,
   input  bcr_regreq_t      regReq,
   input  wire logic        timerEvent,
   input  wire logic        pulseIn,
   input  wire logic        pumpGainRequest,
   output logic [7:0]       rdData_q,
   output logic [5:0]       sinkOn_q,
   output logic             groupALinear_q,
   output logic             pulseGate_q,
   output logic             intOut_q,
   output logic             deviceEnabled_q,
   output logic             pumpGainHigh_q,
   output logic             rampUpTick,
   output logic             rampDownTick
);

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   // every selectable period must fit the shared timer width
   for (genvar c = 0; c < 8; c++) begin : g_chk_step
      if (STEP_CYCLES[c] < 1 || STEP_CYCLES[c] >= (64'd1 << CW)) begin : g_bad
         $error("bcr_backlight_regs: step count does not fit CW");
      end
   end
   for (genvar c = 0; c < 4; c++) begin : g_chk_filt
      if (FILTER_CYCLES[c] < 1 || FILTER_CYCLES[c] >= (64'd1 << CW)) begin : g_bad
         $error("bcr_backlight_regs: filter count does not fit CW");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [7:0]   master_q;
   logic [7:0]   master_d;
   logic [7:0]   sink_q;
   logic [7:0]   sink_d;
   bcr_config_t  config_q;
   bcr_config_t  config_d;
   bcr_options_t options_q;
   bcr_options_t options_d;
   logic         pending_q;
   logic         pending_d;
   logic [7:0]   rdData_d;
   logic         defaults;
   logic         softReset;

   // soft reset request: master write with bit 0 set
   assign softReset = regReq.wr && regReq.addr == `BCR_ADDR_MASTER
                      && regReq.data[`BCR_BIT_SOFT_RST];
   // RULE15: enable pin low
   assign defaults = !hardwareEnablePin;

   always_comb begin
      master_d  = master_q;
      sink_d    = sink_q;
      config_d  = config_q;
      options_d = options_q;
      pending_d = pending_q;
      rdData_d  = 8'h00;
      // RULE16: a write arrives as register address plus one data byte
      if (regReq.wr) begin
         case (regReq.addr)
            // RULE17: undefined bits masked off
            `BCR_ADDR_MASTER: begin
               master_d = regReq.data & `BCR_MASK_MASTER;
            end
            `BCR_ADDR_SINK: begin
               sink_d = regReq.data & `BCR_MASK_SINK;
            end
            `BCR_ADDR_CONFIG: begin
               config_d = bcr_config_t'(regReq.data & `BCR_MASK_CONFIG);
            end
            `BCR_ADDR_OPTIONS: begin
               options_d = bcr_options_t'(regReq.data & `BCR_MASK_OPTIONS);
            end
            default: begin
            end
         endcase
      end
      if (regReq.rd) begin
         case (regReq.addr)
            `BCR_ADDR_MASTER: begin
               rdData_d = master_q;
            end
            `BCR_ADDR_SINK: begin
               rdData_d = sink_q;
            end
            `BCR_ADDR_CONFIG: begin
               rdData_d = config_q;
            end
            `BCR_ADDR_OPTIONS: begin
               rdData_d = options_q;
            end
            `BCR_ADDR_STATUS: begin
               rdData_d[`BCR_BIT_TIMERFLAG] = pending_q;
               // RULE6: status read clears
               pending_d = 1'b0;
            end
            default: begin
               rdData_d = 8'h00;
            end
         endcase
      end
      // a new event wins over the clearing read
      if (timerEvent) begin
         pending_d = 1'b1;
      end
      // RULE3: soft reset restores every default, its own bit reads zero
      if (softReset || defaults) begin
         master_d  = `BCR_RST_MASTER;
         sink_d    = `BCR_RST_SINK;
         config_d  = bcr_config_t'(`BCR_RST_CONFIG);
         options_d = bcr_options_t'(`BCR_RST_OPTIONS);
         pending_d = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         master_q  <= `BCR_RST_MASTER;
         sink_q    <= `BCR_RST_SINK;
         config_q  <= bcr_config_t'(`BCR_RST_CONFIG);
         options_q <= bcr_options_t'(`BCR_RST_OPTIONS);
         pending_q <= 1'b0;
         rdData_q  <= 8'h00;
      end else begin
         master_q  <= master_d;
         sink_q    <= sink_d;
         config_q  <= config_d;
         options_q <= options_d;
         pending_q <= pending_d;
         rdData_q  <= rdData_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sink switching

   logic [5:0] inGroupA;
   logic [5:0] sinkOn_d;

   // sinks one to four always belong to group A
   assign inGroupA[3:0] = 4'hF;
   // RULE9: sink five group
   assign inGroupA[4]   = config_q.sink5GroupSelect;
   // RULE8: sink six group
   assign inGroupA[5]   = config_q.sink6GroupSelect;

   for (genvar s = 0; s < 6; s++) begin : g_sink
      // RULE4: per sink enable
      // RULE1: group A master
      // RULE2: group B master
      assign sinkOn_d[s] = sink_q[s] && hardwareEnablePin
                           && (inGroupA[s] ? master_q[`BCR_BIT_GROUP_A]
                                           : master_q[`BCR_BIT_GROUP_B]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pulse input, curve, interrupt pin

   logic groupALinear_d;
   logic pulseGate_d;
   logic intOut_d;

   always_comb begin
      // RULE7: group A curve
      groupALinear_d = config_q.linearCurve;
      // RULE11: ignored input leaves the gate open
      // RULE10: active low input inverted
      pulseGate_d    = config_q.pulseEnable ? (pulseIn ^ config_q.pulseActiveLow) : 1'b1;
      // RULE5: pin gated by enable
      intOut_d       = pending_q && config_q.intEnable;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         sinkOn_q        <= 6'h00;
         groupALinear_q  <= 1'b0;
         pulseGate_q     <= 1'b1;
         intOut_q        <= 1'b0;
         deviceEnabled_q <= 1'b0;
      end else begin
         sinkOn_q        <= sinkOn_d;
         groupALinear_q  <= groupALinear_d;
         pulseGate_q     <= pulseGate_d;
         intOut_q        <= intOut_d;
         deviceEnabled_q <= hardwareEnablePin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ramp step timers and gain change filter

   logic [CW-1:0] upPeriod;
   logic [CW-1:0] downPeriod;
   logic [CW-1:0] filtPeriod;
   logic          filtRun;
   logic          filtTick;
   logic          pumpGainHigh_d;

   // counts are cut to CW bits on purpose; the elaboration checks keep them in range
   // RULE14: ramp up step time
   assign upPeriod   = CW'(STEP_CYCLES[options_q.rampUpStepTime]);
   // RULE13: ramp down step time
   assign downPeriod = CW'(STEP_CYCLES[options_q.rampDownStepTime]);
   // RULE12: gain filter time
   assign filtPeriod = CW'(FILTER_CYCLES[options_q.pumpGainChangeFilter]);
   assign filtRun    = hardwareEnablePin && (pumpGainRequest != pumpGainHigh_q);

   bcr_interval_timer #(
      .CW     (CW)
   ) u_up_timer (
      .clock  (clock),
      .srst   (srst),
      .run    (hardwareEnablePin),
      .period (upPeriod),
      .tick   (rampUpTick)
   );

   bcr_interval_timer #(
      .CW     (CW)
   ) u_down_timer (
      .clock  (clock),
      .srst   (srst),
      .run    (hardwareEnablePin),
      .period (downPeriod),
      .tick   (rampDownTick)
   );

   bcr_interval_timer #(
      .CW     (CW)
   ) u_filter_timer (
      .clock  (clock),
      .srst   (srst),
      .run    (filtRun),
      .period (filtPeriod),
      .tick   (filtTick)
   );

   // gain follows the request only once it has held for the filter time
   // a tick left over from an earlier run counts only while the request still differs
   always_comb begin
      pumpGainHigh_d = pumpGainHigh_q;
      if (!hardwareEnablePin) begin
         pumpGainHigh_d = 1'b0;
      end else if (filtTick && filtRun) begin
         pumpGainHigh_d = pumpGainRequest;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pumpGainHigh_q <= 1'b0;
      end else begin
         pumpGainHigh_q <= pumpGainHigh_d;
      end
   end

endmodule

/* bench/bcr_backlight_regs_asserts.sv */
// concurrent checks on the backlight register bank ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/100ps

module bcr_backlight_regs_asserts
   import bcr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       hardwareEnablePin,
   input  bcr_regreq_t     regReq,
   input  wire logic       timerEvent,
   input  wire logic [7:0] rdData_q,
   input  wire logic [5:0] sinkOn_q,
   input  wire logic       groupALinear_q,
   input  wire logic       pulseGate_q,
   input  wire logic       intOut_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   wire logic rdStat   = regReq.rd && regReq.addr == 8'h40;
   wire logic rdMaster = regReq.rd && regReq.addr == 8'h00;
   wire logic rdSink   = regReq.rd && regReq.addr == 8'h10;
   wire logic mapped   = regReq.addr inside {8'h00, 8'h10, 8'h20, 8'h30, 8'h40};
   wire logic softRst  = regReq.wr && regReq.addr == 8'h00 && regReq.data[0];

   chk_read_idle:
      assert property (!regReq.rd |=> rdData_q == 8'h00) else $error("read data not idle");
   chk_status_mask:
      assert property (rdStat |=> (rdData_q & 8'hEF) == 8'h00) else $error("status bits");
   chk_master_mask:
      assert property (rdMaster |=> (rdData_q & 8'hF9) == 8'h00) else $error("master bits");
   chk_sink_mask:
      assert property (rdSink |=> rdData_q[7:6] == 2'b00) else $error("sink bits");
   chk_unmapped_zero:
      assert property (regReq.rd && !mapped |=> rdData_q == 8'h00) else $error("unmapped read");
   chk_int_clear:
      assert property (rdStat && !timerEvent ##1 !timerEvent |=> !intOut_q)
         else $error("interrupt not cleared");
   chk_soft_defaults:
      assert property (softRst |-> ##2 (sinkOn_q == 6'h00 && !groupALinear_q && pulseGate_q))
         else $error("soft reset defaults");
   chk_hardware_enable_pin_sinks:
      assert property (!hardwareEnablePin |-> ##2 sinkOn_q == 6'h00) else $error("sinks on");
   chk_hardware_enable_pin_int:
      assert property (!hardwareEnablePin |=> ##1 !intOut_q) else $error("interrupt active");
   chk_hardware_enable_pin_pulse:
      assert property (!hardwareEnablePin |=> ##1 (pulseGate_q && !groupALinear_q))
         else $error("pulse or curve not default");
endmodule

/* bench/bcr_host_model.sv */
// host side of the register port: issues single byte writes and reads
// assumes requests are launched on the falling edge of clock
`timescale 1ns/100ps

module bcr_host_model
   import bcr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [7:0] rdData_q,
   output bcr_regreq_t     regReq
);
   initial regReq = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, data: 8'hFF};

   task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      regReq = '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
      @(negedge clock);
      regReq = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
   endtask

   // a status read clears the interrupt
   task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clock);
      regReq = '{wr: 1'b0, rd: 1'b1, addr: addr, data: ~regReq.data};
      @(negedge clock);
      data = rdData_q;
      regReq = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~regReq.data};
   endtask
endmodule

/* bench/testbench.sv */
// self-checking bench of the backlight register bank with a host model
// assumes shortened step and filter counts; inputs change on the falling edge
`timescale 1ns/100ps

module testbench
   import bcr_pkg::*;
;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        hardware_enable_pin = 1'b1;
   logic        timerEvent = 1'b0;
   logic        pulseIn = 1'b0;
   logic        pumpReq = 1'b0;
   bcr_regreq_t regReq;
   logic [7:0]  rdData_q;
   logic [5:0]  sinkOn_q;
   logic        groupALinear_q;
   logic        pulseGate_q;
   logic        intOut_q;
   logic        devOn_q;
   logic        pumpHigh_q;
   logic        upTick;
   logic        downTick;
   logic [7:0]  v, a, d, s, c, m, o;
   logic [7:0]  addrs [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40};
   int          i;
   int          g;
   localparam int unsigned STEPS [8] = '{3, 4, 5, 6, 7, 8, 9, 10};
   int          cycles = 0;
   int          mismatches = 0;
   int          nChecks = 0;

   always #10 clock = ~clock;

   bcr_backlight_regs #(
      .STEP_CYCLES   (STEPS),
      .FILTER_CYCLES ('{5, 4, 3, 2})
   ) u_dut (
      .clock(clock), .srst(srst), .hardwareEnablePin(hardware_enable_pin), .regReq(regReq),
      .timerEvent(timerEvent), .pulseIn(pulseIn), .pumpGainRequest(pumpReq),
      .rdData_q(rdData_q), .sinkOn_q(sinkOn_q), .groupALinear_q(groupALinear_q),
      .pulseGate_q(pulseGate_q), .intOut_q(intOut_q), .deviceEnabled_q(devOn_q),
      .pumpGainHigh_q(pumpHigh_q), .rampUpTick(upTick), .rampDownTick(downTick)
   );

   bcr_host_model u_host (.clock(clock), .rdData_q(rdData_q), .regReq(regReq));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] maskOf(logic [7:0] adr);
      case (adr)
         8'h00: return 8'h06;
         8'h10: return 8'h3F;
         8'h20: return 8'hCF;
         8'h30: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] defOf(logic [7:0] adr);
      return (adr == 8'h20) ? 8'h0C : 8'h00;
   endfunction

   function automatic logic [7:0] sinkExp(logic [7:0] sk, logic [7:0] cf, logic [7:0] ms);
      logic [5:0] grpA;
      grpA = {cf[3], cf[2], 4'hF};
      return {2'b00, sk[5:0] & ((grpA & {6{ms[2]}}) | (~grpA & {6{ms[1]}}))};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      u_host.writeReg(adr, dat);
   endtask

   task automatic rd(input logic [7:0] adr);
      u_host.readReg(adr, v);
   endtask

   // cycles from one tick to the next; the first tick seen may be cut short by a code change
   task automatic measureGap(input logic pickDown, output int gap);
      gap = 0;
      @(negedge clock);
      while (!(pickDown ? downTick : upTick)) @(negedge clock);
      gap = 1;
      @(negedge clock);
      while (!(pickDown ? downTick : upTick)) begin
         @(negedge clock);
         gap++;
      end
   endtask

   task automatic timerPulse();
      @(negedge clock) timerEvent = 1'b1;
      @(negedge clock) timerEvent = 1'b0;
      @(negedge clock);
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         printVerdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h2A5204CE));
      repeat (8) @(negedge clock);
      srst = 1'b0;
      for (i = 0; i < 5; i++) begin
         rd(addrs[i]);
         check("reset value", v, defOf(addrs[i]));
      end
      repeat (24) begin
         a = addrs[$urandom_range(0, 3)];
         d = 8'($urandom);
         d[0] = (a == 8'h00) ? 1'b0 : d[0];
         wr(a, d);
         rd(a);
         check("readback", v, d & maskOf(a));
      end
      rd(8'h50);
      check("unmapped", v, 8'h00);
      wr(8'h40, 8'hFF);
      rd(8'h40);
      check("status write", v, 8'h00);
      // group enables, assignment, curve and pulse gate
      repeat (24) begin
         s = 8'($urandom);
         c = 8'($urandom) & 8'h7F;
         m = 8'($urandom) & 8'hFE;
         pulseIn = 1'($urandom);
         wr(8'h10, s);
         wr(8'h20, c);
         wr(8'h00, m);
         @(negedge clock);
         check("sinks", {2'b00, sinkOn_q}, sinkExp(s, c, m));
         check("curve", {7'h00, groupALinear_q}, {7'h00, c[6]});
         check("pulse", {7'h00, pulseGate_q}, {7'h00, c[0] ? pulseIn ^ c[1] : 1'b1});
      end
      // soft reset with other bits set
      wr(8'h30, 8'hA5);
      wr(8'h00, 8'h07);
      for (i = 0; i < 4; i++) begin
         rd(addrs[i]);
         check("soft reset", v, defOf(addrs[i]));
      end
      // interrupt enabled, then cleared by the status read
      wr(8'h20, 8'h80);
      timerPulse();
      check("int pin", {7'h00, intOut_q}, 8'h01);
      rd(8'h40);
      check("status", v, 8'h10);
      @(negedge clock);
      check("int cleared", {7'h00, intOut_q}, 8'h00);
      rd(8'h40);
      check("status clear", v, 8'h00);
      wr(8'h20, 8'h00);
      timerPulse();
      check("int gated", {7'h00, intOut_q}, 8'h00);
      rd(8'h40);
      check("status gated", v, 8'h10);
      // gain filter follows a held request
      wr(8'h30, 8'h00);
      pumpReq = 1'b1;
      repeat (12) @(negedge clock);
      check("gain high", {7'h00, pumpHigh_q}, 8'h01);
      wr(8'h30, 8'hC0);
      pumpReq = 1'b0;
      repeat (8) @(negedge clock);
      check("gain low", {7'h00, pumpHigh_q}, 8'h00);
      // ramp step times, slowest and fastest codes first, then random
      for (i = 0; i < 8; i++) begin
         o = (i < 2) ? ((i == 0) ? 8'h38 : 8'h07) : (8'($urandom) & 8'h3F);
         wr(8'h30, o);
         measureGap(1'b0, g);
         check("ramp up", 8'(g), 8'(STEPS[o[2:0]]));
         measureGap(1'b1, g);
         check("ramp down", 8'(g), 8'(STEPS[o[5:3]]));
      end
      wr(8'h10, 8'h3F);
      wr(8'h20, 8'h83);
      wr(8'h00, 8'h06);
      @(negedge clock) hardware_enable_pin = 1'b0;
      @(negedge clock);
      check("device off", {7'h00, devOn_q}, 8'h00);
      check("sinks off", {2'b00, sinkOn_q}, 8'h00);
      hardware_enable_pin = 1'b1;
      for (i = 0; i < 4; i++) begin
         rd(addrs[i]);
         check("enable pin", v, defOf(addrs[i]));
      end
      check("device on", {7'h00, devOn_q}, 8'h01);
      printVerdict();
   end
endmodule

bind bcr_backlight_regs bcr_backlight_regs_asserts u_chk (
   .clock(clock), .srst(srst), .hardwareEnablePin(hardwareEnablePin), .regReq(regReq),
   .timerEvent(timerEvent), .rdData_q(rdData_q), .sinkOn_q(sinkOn_q),
   .groupALinear_q(groupALinear_q), .pulseGate_q(pulseGate_q), .intOut_q(intOut_q)
);
